// *** hdl/acq_ctrl.sv ***
// conversion sequencer, serial instruction decoder and register file
`timescale 1ns/10ps
module acq_ctrl
  import acq_ctrl_pkg::*;
(
  input wire logic core_clk, // 25 mhz system clock
  input wire logic reset, // synchronous, active high
  input wire logic cyc_i, // wishbone cycle
  input wire logic stb_i, // wishbone strobe
  input wire logic we_i, // wishbone write enable
  input wire logic [6:0] adr_i, // wishbone byte address
  input wire logic [3:0] sel_i, // wishbone byte selects
  input wire logic [31:0] dat_i, // wishbone write data
  output logic [31:0] dat_o, // wishbone read data
  output logic ack_o, // wishbone acknowledge
  input wire logic sclk_pin, // serial bit clock
  input wire logic cs_n_pin, // serial chip select, active low
  input wire logic bidirectional_serial_input_i, // serial data in
  output logic bidirectional_serial_input_o, // read data on input pin
  output logic bidirectional_serial_input_oe, // drive enable, high drives
  output logic serial_dout, // serial data out
  input wire logic edge_select_pin, // high: rising edge is active
  input wire logic conversion_clock_in, // undivided conversion clock
  input wire logic convert_pin, // hardware conversion trigger
  input wire logic reset_pin, // device reset pin, active high
  input wire logic oscillator_enable_pin, // oscillator enable pin
  input wire logic overload_in, // amplifier overload flag
  input wire logic sar_compare, // comparator: input above trial code
  output logic [11:0] sar_trial, // trial code to the converter
  output logic [2:0] pga_gain_code, // amplifier gain code
  output logic [3:0] channel_select_code, // input channel code
  output logic oscillator_enable_out, // oscillator on
  output logic busy // conversion in progress
);

  typedef struct packed {
    logic [2:0] sclk_s;
    logic [1:0] cs_s;
    logic [1:0] din_s;
    logic [2:0] conversion_clock_in_s;
    logic [2:0] trig_s;
    logic [1:0] edge_s;
    logic [1:0] rstp_s;
    logic [1:0] ovr_s;
    logic [1:0] oscp_s;
    logic soft_rst;
    conv_state_t cst;
    logic [2:0] div_cnt;
    logic [5:0] period;
    logic [1:0] wait_cnt;
    logic [1:0] trig_cnt;
    logic [11:0] trial;
    logic [11:0] result;
    logic ovr;
    logic bin;
    logic [1:0] cfd;
    logic [6:0] gain_mux;
    logic [3:0] dio;
    logic [3:0] dio_oe;
    logic [5:0] refosc;
    logic lsb_first;
    logic three_wire;
    ser_state_t sst;
    logic [7:0] shreg;
    logic [2:0] bitcnt;
    logic second;
    logic [4:0] idx;
    logic wide;
    logic dout;
    logic ack;
    logic [31:0] dat;
  } state_t;

  state_t q_r;
  state_t q_nxt;
  logic divided_conversion_clock_tick;
  logic direct_req;
  logic byte_done;
  logic conv_done;
  logic [7:0] byte_in;

  function automatic logic [7:0] rev8(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7 - i];
    end
    return r;
  endfunction

  function automatic logic [7:0] reg_read(input state_t s,
                                          input logic [4:0] i);
    logic bsy;
    bsy = (s.cst != CONV_IDLE);
    unique case (i)
      IDX_RESULT_LO: reg_read = {s.result[3:0], 3'h0, s.ovr};
      IDX_RESULT_HI: reg_read = s.result[11:4];
      IDX_ADC_CTRL: reg_read = {2'h0, s.bin, 3'h0, s.cfd};
      IDX_GAIN_MUX: reg_read = {bsy, s.gain_mux};
      IDX_DIO_STATE: reg_read = {bsy, 3'h0, s.dio};
      IDX_DIO_CTRL: reg_read = {4'h0, s.dio_oe};
      IDX_REF_OSC: reg_read = {2'h0, s.refosc};
      IDX_SER_CTRL: reg_read = {s.lsb_first, s.three_wire, 4'h0,
                                s.three_wire, s.lsb_first};
      IDX_ID: reg_read = ID_VALUE;
      default: reg_read = RST_BYTE;
    endcase
  endfunction

  // stores a byte; a write of zero-index or cnv bit has side effects
  function automatic state_t reg_write(input state_t s,
                                       input logic [4:0] i,
                                       input logic [7:0] d);
    state_t r;
    r = s;
    unique case (i)
      IDX_ADC_CTRL: begin
        r.bin = d[BIN_BIT];
        r.cfd = d[1:0];
      end
      IDX_GAIN_MUX: r.gain_mux = d[6:0];
      IDX_DIO_STATE: r.dio = d[3:0];
      IDX_DIO_CTRL: r.dio_oe = d[3:0];
      IDX_REF_OSC: r.refosc = d[5:0];
      IDX_SER_CTRL: begin
        r.lsb_first = d[LSB_FIRST_BIT];
        r.three_wire = d[THREE_WIRE_BIT];
      end
      default: r = s;
    endcase
    return r;
  endfunction

  function automatic logic cnv_hit(input logic [4:0] i,
                                   input logic [7:0] d);
    return ((i == IDX_GAIN_MUX) || (i == IDX_DIO_STATE)) && d[CNV_BIT];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic act;
    logic conversion_clock_in_rise;
    logic start_req;
    logic start_now;
    logic [11:0] tc;
    logic [3:0] bitpos;
    logic [7:0] ld;
    logic [4:0] wb_idx;
    act = 1'b0;
    conversion_clock_in_rise = 1'b0;
    start_req = 1'b0;
    start_now = 1'b0;
    tc = 12'h000;
    bitpos = 4'h0;
    ld = 8'h00;
    wb_idx = adr_i[6:2];
    q_nxt = q_r;
    divided_conversion_clock_tick = 1'b0;
    direct_req = 1'b0;
    byte_done = 1'b0;
    conv_done = 1'b0;
    q_nxt.soft_rst = 1'b0;
    q_nxt.sclk_s = {q_r.sclk_s[1:0], sclk_pin};
    q_nxt.cs_s = {q_r.cs_s[0], cs_n_pin};
    q_nxt.din_s = {q_r.din_s[0], bidirectional_serial_input_i};
    q_nxt.conversion_clock_in_s = {q_r.conversion_clock_in_s[1:0], conversion_clock_in};
    q_nxt.trig_s = {q_r.trig_s[1:0], convert_pin};
    q_nxt.edge_s = {q_r.edge_s[0], edge_select_pin};
    q_nxt.rstp_s = {q_r.rstp_s[0], reset_pin};
    q_nxt.ovr_s = {q_r.ovr_s[0], overload_in};
    q_nxt.oscp_s = {q_r.oscp_s[0], oscillator_enable_pin};
    byte_in = {q_r.shreg[6:0], q_r.din_s[1]};

    // wishbone slave: ack one cycle after the request, write at ack edge
    q_nxt.ack = cyc_i && stb_i && !q_r.ack;
    if (cyc_i && stb_i && !q_r.ack) begin
      q_nxt.dat = {24'h000000, reg_read(q_r, wb_idx)};
    end
    if (cyc_i && stb_i && q_r.ack && we_i && sel_i[0]) begin
      q_nxt = reg_write(q_nxt, wb_idx, dat_i[7:0]);
      start_req = cnv_hit(wb_idx, dat_i[7:0]);
      if (wb_idx == IDX_RESULT_LO) begin
        q_nxt.soft_rst = 1'b1;
      end
    end

    // serial port
    act = q_r.edge_s[1] ? (q_r.sclk_s[1] && !q_r.sclk_s[2]) :
                          (!q_r.sclk_s[1] && q_r.sclk_s[2]);
    if (q_r.cs_s[1]) begin
      q_nxt.sst = SER_INSTR;
      q_nxt.bitcnt = 3'h0;
    end else if (act) begin
      q_nxt.shreg = byte_in;
      q_nxt.bitcnt = q_r.bitcnt + 3'h1;
      if (q_r.sst == SER_RDATA) begin
        q_nxt.dout = q_r.shreg[6];
      end
      if (q_r.bitcnt == 3'h7) begin
        byte_done = 1'b1;
        unique case (q_r.sst)
          SER_INSTR: begin
            q_nxt.idx = byte_in[4:0];
            q_nxt.wide = byte_in[WIDE_BIT];
            q_nxt.second = 1'b0;
            if (byte_in[MODE_BIT]) begin
              q_nxt.gain_mux = byte_in[6:0];
              direct_req = 1'b1;
            end else if (byte_in[RD_BIT]) begin
              ld = reg_read(q_r, byte_in[4:0]);
              q_nxt.shreg = q_r.lsb_first ? rev8(ld) : ld;
              q_nxt.dout = q_r.lsb_first ? ld[0] : ld[7];
              q_nxt.sst = SER_RDATA;
            end else if (byte_in[4:0] == IDX_RESULT_LO &&
                         !byte_in[WIDE_BIT]) begin
              q_nxt.soft_rst = 1'b1;
            end else begin
              q_nxt.sst = SER_WDATA;
            end
          end
          SER_WDATA: begin
            q_nxt = reg_write(q_nxt, q_r.idx, byte_in);
            start_req = start_req || cnv_hit(q_r.idx, byte_in);
            if (q_r.wide && !q_r.second) begin
              q_nxt.idx = q_r.idx ^ 5'h01;
              q_nxt.second = 1'b1;
            end else begin
              q_nxt.sst = SER_INSTR;
            end
          end
          SER_RDATA: begin
            if (q_r.wide && !q_r.second) begin
              ld = reg_read(q_r, q_r.idx ^ 5'h01);
              q_nxt.idx = q_r.idx ^ 5'h01;
              q_nxt.second = 1'b1;
              q_nxt.shreg = q_r.lsb_first ? rev8(ld) : ld;
              q_nxt.dout = q_r.lsb_first ? ld[0] : ld[7];
            end else begin
              q_nxt.sst = SER_INSTR;
            end
          end
        endcase
      end
    end
    start_req = start_req || direct_req;

    // divided conversion clock
    conversion_clock_in_rise = q_r.conversion_clock_in_s[1] && !q_r.conversion_clock_in_s[2];
    if (conversion_clock_in_rise) begin
      if (q_r.div_cnt == 3'((4'h1 << q_r.cfd) - 4'h1)) begin
        q_nxt.div_cnt = 3'h0;
        divided_conversion_clock_tick = 1'b1;
      end else begin
        q_nxt.div_cnt = q_r.div_cnt + 3'h1;
      end
    end

    // trigger pin: rising edge, then high for two conversion clock edges
    if (!q_r.trig_s[1]) begin
      q_nxt.trig_cnt = 2'h0;
    end else if (!q_r.trig_s[2]) begin
      q_nxt.trig_cnt = 2'h1;
    end else if (conversion_clock_in_rise && q_r.trig_cnt != 2'h0) begin
      if (q_r.trig_cnt == TRIG_HOLD_EDGES) begin
        q_nxt.trig_cnt = 2'h0;
        start_now = (q_r.cst == CONV_IDLE);
      end else begin
        q_nxt.trig_cnt = q_r.trig_cnt + 2'h1;
      end
    end

    // conversion sequencer
    unique case (q_r.cst)
      CONV_IDLE: begin
        if (start_now) begin
          q_nxt.cst = CONV_PGA;
          q_nxt.period = 6'h00;
          q_nxt.div_cnt = 3'h0;
        end else if (start_req) begin
          q_nxt.cst = CONV_WAIT;
          q_nxt.wait_cnt = 2'h0;
        end
      end
      CONV_WAIT: begin
        if (divided_conversion_clock_tick) begin
          if (q_r.wait_cnt == DIRECT_START_TICKS - 2'h1) begin
            q_nxt.cst = CONV_PGA;
            q_nxt.period = 6'h00;
          end else begin
            q_nxt.wait_cnt = q_r.wait_cnt + 2'h1;
          end
        end
      end
      CONV_PGA: begin
        if (divided_conversion_clock_tick) begin
          q_nxt.period = q_r.period + 6'h01;
          if (q_r.period == PGA_PERIODS - 6'h01) begin
            q_nxt.cst = CONV_SAR;
            q_nxt.trial = SAR_MSB;
          end
        end
      end
      CONV_SAR: begin
        bitpos = 4'(CONV_PERIODS - 6'h01 - q_r.period);
        if (divided_conversion_clock_tick) begin
          q_nxt.period = q_r.period + 6'h01;
          q_nxt.trial[bitpos] = sar_compare;
          if (q_r.period == CONV_PERIODS - 6'h01) begin
            conv_done = 1'b1;
            tc = q_nxt.trial ^ SAR_MSB;
            if (q_r.gain_mux[SINGLE_BIT] && tc[11]) begin
              tc = RST_RESULT;
            end
            q_nxt.result = q_r.bin ? (tc ^ SAR_MSB) : tc;
            q_nxt.ovr = q_r.ovr_s[1];
            q_nxt.cst = CONV_IDLE;
          end else begin
            q_nxt.trial[bitpos - 4'h1] = 1'b1;
          end
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk) begin
    if (reset || q_r.rstp_s[1] || q_r.soft_rst) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign ack_o = q_r.ack;
  assign dat_o = q_r.dat;
  assign serial_dout = q_r.dout;
  assign bidirectional_serial_input_o = q_r.dout;
  assign bidirectional_serial_input_oe = q_r.three_wire &&
                                         (q_r.sst == SER_RDATA) &&
                                         !q_r.cs_s[1];
  assign sar_trial = q_r.trial;
  assign pga_gain_code = q_r.gain_mux[6:4];
  assign channel_select_code = q_r.gain_mux[3:0];
  assign oscillator_enable_out = q_r.oscp_s[1] || q_r.refosc[OSCE_BIT];
  assign busy = (q_r.cst == CONV_PGA) || (q_r.cst == CONV_SAR);

  ////////////////////////////////////////////////////////////////////////
  logic [6:0] tick_seen_r;
  always_ff @(posedge core_clk) begin
    if (reset || q_nxt.cst == CONV_PGA && q_r.cst != CONV_PGA) begin
      tick_seen_r <= 7'h00;
    end else if (busy && divided_conversion_clock_tick) begin
      tick_seen_r <= tick_seen_r + 7'h01;
    end
  end

  property p_conv_len;
    @(posedge core_clk) disable iff (reset)
      $fell(busy) && !$past(q_r.rstp_s[1]) && !$past(q_r.soft_rst)
      |-> tick_seen_r == 7'd48;
  endproperty
  a_conv_len: assert property (p_conv_len)
    else $error("conversion did not last 48 divided periods");

  property p_pga_len;
    @(posedge core_clk) disable iff (reset)
      $rose(q_r.cst == CONV_SAR) |-> tick_seen_r == 7'd36;
  endproperty
  a_pga_len: assert property (p_pga_len)
    else $error("amplifier phase not 36 periods");

  property p_sar_start;
    @(posedge core_clk) disable iff (reset)
      $rose(q_r.cst == CONV_SAR) |-> q_r.trial == 12'h800;
  endproperty
  a_sar_start: assert property (p_sar_start)
    else $error("approximation did not start at msb");

  property p_cnv_write;
    @(posedge core_clk) disable iff (reset || q_r.rstp_s[1])
      cyc_i && stb_i && q_r.ack && we_i && sel_i[0] &&
      adr_i[6:2] == 5'h04 && dat_i[7] && q_r.cst == CONV_IDLE
      |=> q_r.cst == CONV_WAIT ##[1:200] busy;
  endproperty
  a_cnv_write: assert property (p_cnv_write)
    else $error("cnv bit write did not start conversion");

  property p_trig;
    @(posedge core_clk) disable iff (reset || q_r.rstp_s[1])
      q_r.trig_s[1] && q_r.trig_s[2] && q_r.trig_cnt == 2'd2 &&
      q_r.conversion_clock_in_s[1] && !q_r.conversion_clock_in_s[2] && q_r.cst == CONV_IDLE
      |=> busy && q_r.period == 6'h00;
  endproperty
  a_trig: assert property (p_trig)
    else $error("trigger did not start at second clock edge");

  property p_direct;
    @(posedge core_clk) disable iff (reset || q_r.rstp_s[1])
      direct_req && q_r.cst == CONV_IDLE
      |=> q_r.gain_mux == $past(byte_in[6:0]) && q_r.cst == CONV_WAIT;
  endproperty
  a_direct: assert property (p_direct)
    else $error("direct byte not copied into gain register");

  property p_single;
    @(posedge core_clk) disable iff (reset || q_r.rstp_s[1])
      conv_done && q_r.gain_mux[3] && !q_r.bin |=> !q_r.result[11];
  endproperty
  a_single: assert property (p_single)
    else $error("single-ended result went negative");

  property p_pair;
    @(posedge core_clk) disable iff (reset || q_r.rstp_s[1])
      byte_done && q_r.sst == SER_WDATA && q_r.wide && !q_r.second
      |=> q_r.idx == ($past(q_r.idx) ^ 5'h01) && q_r.second;
  endproperty
  a_pair: assert property (p_pair)
    else $error("second byte index wrong");

  property p_wb_ack;
    @(posedge core_clk) disable iff (reset)
      cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o;
  endproperty
  a_wb_ack: assert property (p_wb_ack)
    else $error("bus acknowledge not one cycle after request");

  c_conv: cover property (@(posedge core_clk) disable iff (reset)
    conv_done);
  c_direct: cover property (@(posedge core_clk) disable iff (reset)
    direct_req);
  c_read16: cover property (@(posedge core_clk) disable iff (reset)
    byte_done && q_r.sst == SER_RDATA && q_r.second);
endmodule

// *** hdl/acq_ctrl_pkg.sv ***
// shared constants and types of the acquisition control block
package acq_ctrl_pkg;
  // register indexes; byte address on the bus is four times the index
  localparam logic [4:0] IDX_RESULT_LO = 5'h00;
  localparam logic [4:0] IDX_RESULT_HI = 5'h01;
  localparam logic [4:0] IDX_PGA_VALID = 5'h02;
  localparam logic [4:0] IDX_ADC_CTRL = 5'h03;
  localparam logic [4:0] IDX_GAIN_MUX = 5'h04;
  localparam logic [4:0] IDX_DIO_STATE = 5'h05;
  localparam logic [4:0] IDX_DIO_CTRL = 5'h06;
  localparam logic [4:0] IDX_REF_OSC = 5'h07;
  localparam logic [4:0] IDX_SER_CTRL = 5'h18;
  localparam logic [4:0] IDX_ID = 5'h1f;
  // field positions
  localparam int CNV_BIT = 7;
  localparam int BIN_BIT = 5;
  localparam int OSCE_BIT = 4;
  localparam int SINGLE_BIT = 3;
  localparam int LSB_FIRST_BIT = 0;
  localparam int THREE_WIRE_BIT = 1;
  localparam int MODE_BIT = 7;
  localparam int RD_BIT = 6;
  localparam int WIDE_BIT = 5;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [11:0] RST_RESULT = 12'h000;
  // arbitrary identification value
  localparam logic [7:0] ID_VALUE = 8'h5a;
  // timing counts, in divided or undivided conversion clock periods
  localparam logic [5:0] CONV_PERIODS = 6'd48;
  localparam logic [5:0] PGA_PERIODS = 6'd36;
  localparam logic [5:0] SAR_PERIODS = 6'd12;
  localparam logic [1:0] DIRECT_START_TICKS = 2'd2;
  localparam logic [1:0] TRIG_HOLD_EDGES = 2'd2;
  localparam logic [11:0] SAR_MSB = 12'h800;

  typedef enum logic [1:0] {
    CONV_IDLE, CONV_WAIT, CONV_PGA, CONV_SAR
  } conv_state_t;

  typedef enum logic [1:0] {
    SER_INSTR, SER_WDATA, SER_RDATA
  } ser_state_t;
endpackage

// *** verif/acq_ctrl_tb_top.sv ***
// self-checking bench of the acquisition control block
`timescale 1ns/10ps
module acq_ctrl_tb_top;
  import acq_ctrl_pkg::*;
  typedef struct packed {
    logic [1:0] src;
    logic [7:0] g4;
    logic [1:0] df;
    logic bin;
    logic ovr;
    logic [11:0] tgt;
    logic [11:0] res;
  } row_t;
  logic core_clk, reset, cyc, stb, we, sck, cs_n, mosi, es, tw;
  logic cpin, rpin, opin, ovr, ack, sdo, so, soe, osc, busy;
  logic [1:0] cdiv;
  logic [2:0] gain;
  logic [3:0] chan;
  logic [6:0] adr;
  logic [7:0] q;
  logic [11:0] tgt, trial;
  logic [15:0] sd;
  logic [31:0] wdat, rdat;
  wire sw = soe ? so : mosi;
  int n_fail = 0;
  int samples_checked = 0;
  int blen = 0;
  row_t rows[8] = '{
    '{2'd0, 8'h97, 2'd0, 1'b0, 1'b0, 12'ha37, 12'h237},
    '{2'd1, 8'hb4, 2'd0, 1'b0, 1'b1, 12'h123, 12'h923},
    '{2'd2, 8'h2c, 2'd0, 1'b0, 1'b0, 12'h100, 12'h000},
    '{2'd3, 8'h5b, 2'd1, 1'b0, 1'b0, 12'hfff, 12'h7ff},
    '{2'd0, 8'he8, 2'd0, 1'b1, 1'b0, 12'h955, 12'h955},
    '{2'd0, 8'h80, 2'd0, 1'b0, 1'b0, 12'h000, 12'h800},
    '{2'd1, 8'hc0, 2'd2, 1'b0, 1'b0, 12'h7ff, 12'hfff},
    '{2'd0, 8'hf3, 2'd0, 1'b0, 1'b0, 12'hfff, 12'h7ff}
  };
  acq_ctrl acq_ctrl_inst (
    .core_clk(core_clk), .reset(reset), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(wdat), .dat_o(rdat),
    .ack_o(ack), .sclk_pin(sck ^ ~es), .cs_n_pin(cs_n),
    .bidirectional_serial_input_i(sw),
    .bidirectional_serial_input_o(so),
    .bidirectional_serial_input_oe(soe), .serial_dout(sdo),
    .edge_select_pin(es), .conversion_clock_in(cdiv[1]),
    .convert_pin(cpin), .reset_pin(rpin), .oscillator_enable_pin(opin),
    .overload_in(ovr), .sar_compare(tgt >= trial), .sar_trial(trial),
    .pga_gain_code(gain), .channel_select_code(chan),
    .oscillator_enable_out(osc), .busy(busy)
  );
  serial_host_model serial_host_model_inst (
    .core_clk(core_clk), .miso(tw ? sw : sdo), .sck(sck), .cs_n(cs_n),
    .mosi(mosi)
  );
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) cdiv <= cdiv + 2'd1;
  always @(negedge core_clk) if (busy === 1'b1) blen++;
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [4:0] i,
                    input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    wdat <= {24'h0, d};
    // ack and read data are taken at the rising edge that samples ack high
    do begin
      @(posedge core_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) begin
      n_fail++;
      conclude();
    end
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wait_busy(input logic v, input int lim);
    int n;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (busy !== v && n < lim);
    if (busy !== v) begin
      n_fail++;
      conclude();
    end
    @(posedge core_clk);
  endtask
  task automatic run(input row_t r);
    tgt <= r.tgt;
    ovr <= r.ovr;
    wb(1'b1, IDX_ADC_CTRL, {2'b00, r.bin, 3'b000, r.df});
    if (r.src != 2'd0) wb(1'b1, IDX_GAIN_MUX, {1'b0, r.g4[6:0]});
    blen = 0;
    case (r.src)
      2'd0: serial_host_model_inst.frame(r.g4, 0, 16'h0, sd);
      2'd1: wb(1'b1, IDX_GAIN_MUX, r.g4);
      2'd2: wb(1'b1, IDX_DIO_STATE, 8'h80);
      default: begin
        cpin <= 1'b1;
        repeat (16) @(posedge core_clk);
        cpin <= 1'b0;
      end
    endcase
    wait_busy(1'b1, 100);
    wb(1'b0, IDX_GAIN_MUX, 8'h00);
    chk(q, {1'b1, r.g4[6:0]});
    wait_busy(1'b0, 2000);
    chk(blen > (188 << r.df) && blen < (196 << r.df), 1'b1);
    chk(gain, r.g4[6:4]);
    chk(chan, r.g4[3:0]);
    wb(1'b0, IDX_RESULT_HI, 8'h00);
    chk(q, r.res[11:4]);
    wb(1'b0, IDX_RESULT_LO, 8'h00);
    chk(q, {r.res[3:0], 3'b000, r.ovr});
    $display("test conversion row done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge core_clk);
    n_fail++;
    conclude();
  end
  initial begin
    core_clk = 1'b0;
    cdiv = 2'd0;
    {reset, cyc, stb, we, cpin, rpin, opin, ovr, tw} = 9'h100;
    es = 1'b1;
    adr = 7'h00;
    wdat = 32'h0;
    tgt = 12'h000;
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    wb(1'b0, IDX_GAIN_MUX, 8'h00);
    chk(q, RST_BYTE);
    chk(gain, 3'b000);
    wb(1'b0, IDX_ID, 8'h00);
    chk(q, ID_VALUE);
    wb(1'b0, 5'h08, 8'h00);
    chk(q, 8'h00);
    $display("test reset values done");
    foreach (rows[k]) run(rows[k]);
    // last row left 0x7ff without overload in the result registers
    serial_host_model_inst.frame(8'h61, 2, 16'h0, sd);
    chk(sd, 16'h7ff0);
    serial_host_model_inst.frame(8'h26, 2, 16'h0a10, sd);
    wb(1'b0, IDX_REF_OSC, 8'h00);
    chk(q, 8'h10);
    chk(osc, 1'b1);
    serial_host_model_inst.frame(8'h18, 1, 16'h8300, sd);
    es <= 1'b0;
    tw <= 1'b1;
    @(posedge core_clk);
    serial_host_model_inst.frame(8'h41, 1, 16'h0, sd);
    chk(sd[15:8], 8'hfe);
    es <= 1'b1;
    tw <= 1'b0;
    $display("test serial done");
    wb(1'b1, IDX_REF_OSC, 8'h00);
    chk(osc, 1'b0);
    opin <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk(osc, 1'b1);
    opin <= 1'b0;
    rpin <= 1'b1;
    repeat (4) @(posedge core_clk);
    rpin <= 1'b0;
    repeat (8) @(posedge core_clk);
    wb(1'b0, IDX_DIO_CTRL, 8'h00);
    chk(q, 8'h00);
    $display("test pins done");
    conclude();
  end
endmodule

// *** verif/serial_host_model.sv ***
// serial host model that frames instruction and data bytes
`timescale 1ns/10ps
module serial_host_model (
  input wire logic core_clk, // paces the bit timing
  input wire logic miso, // data seen from the device
  output logic sck, // rising edge is the active edge
  output logic cs_n, // chip select, active low
  output logic mosi // host data
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  task automatic half();
    repeat (8) @(posedge core_clk);
  endtask
  task automatic xfer(input logic [7:0] tx, input logic drv,
                      output logic [7:0] rx);
    for (int b = 7; b >= 0; b--) begin
      // a released line toggles every bit
      mosi <= drv ? tx[b] : ~mosi;
      half();
      rx[b] = miso;
      sck <= 1'b1;
      half();
      sck <= 1'b0;
    end
  endtask
  // instruction byte, then n data bytes written or read
  task automatic frame(input logic [7:0] ins, input int n,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [7:0] b;
    rd = 16'h0000;
    cs_n <= 1'b0;
    xfer(ins, 1'b1, b);
    for (int i = 0; i < n; i++) begin
      xfer(wd[15-8*i -: 8], !ins[6], b);
      rd[15-8*i -: 8] = b;
    end
    half();
    cs_n <= 1'b1;
    mosi <= ~mosi;
    half();
  endtask
endmodule
